// ===== src/sbus_ctrl_defs.vh
// Constants for the addressed serial bus control block.
// Included by the design file, the checker and the bench; definitions only.
`ifndef SBUS_CTRL_DEFS_VH
`define SBUS_CTRL_DEFS_VH
`define ADDR_MODE_CTRL0 16'hff60
`define ADDR_BUS_CTRL 16'hff61
`define ADDR_SLAVE_ADDR 16'hff62
`define ADDR_SHIFT_REG 16'hff63
`define ADDR_INT_STATUS 16'hff64
`define ADDR_INT_MASK 16'hff65
`define ADDR_INT_TIMING 16'hff66
`define BIT_CHAN_EN 7
`define BIT_MATCH 6
`define BIT_WAKEUP 5
`define BIT_CMD_DET 3
`define BIT_REL_DET 2
`define BIT_CMD_TRIG 1
`define BIT_REL_TRIG 0
`define BIT_INT_SRC_SEL 5
`define IRQ_XFER 0
`define IRQ_REL 1
`define IRQ_CMD 2
`define RESET_BYTE 8'h00
`define LAST_BIT_IDX 4'h7
`endif

// ===== src/sbus_ctrl.v
// Control and status logic of the addressed two-wire serial bus, channel 0.
// Assumes a CPU register port on clk_sys_i; serial clock and bus line come from
// pins and are synchronised here. Shifting is done locally, eight bits, MSB first.
// Overview of operation
// RQ1 - With wakeup match off, every completed transfer raises the transfer interrupt.
// RQ2 - With wakeup match on, only an address after release and command that matches raises it.
// RQ3 - The address match flag at mode bit 6 shows slave address equal to shift register.
// RQ4 - The address match flag reads 0 while the channel is disabled.
// RQ5 - The channel enable stops the channel at 0 and lets it run at 1.
// RQ6 - Software keeps interrupt source select at 0 when using wakeup match.
// RQ7 - Reset loads 00h into the bus control and status register.
// RQ8 - Writing 1 to release trigger sets the output latch to 1.
// RQ9 - Release trigger self-clears after the latch is set and is held 0 when disabled.
// RQ10 - Writing 1 to command trigger clears the output latch to 0.
// RQ11 - Command trigger self-clears after the latch is cleared and is held 0 when disabled.
// RQ12 - Release detected sets when a bus release is seen on the line.
// RQ13 - Release detected clears on transfer start, address mismatch, disable or reset.
// RQ14 - Command detected sets when a command signal is seen on the line.
// RQ15 - Trigger bits read back as 0.
// RQ16 - Detection flags are read-only.
// RQ17 - The output latch drives the open-drain line whenever no shift is running.
`include "sbus_ctrl_defs.vh"
module sbus_ctrl (
  input wire clk_sys_i,
  input wire arst_n_i,
  input wire [15:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire serial_clk_i,
  input wire bus_line_i,
  output reg bus_line_oe_o,
  output reg bus_line_o,
  output reg irq_o
);
  reg rst_s1_q;
  reg rst_n_q;
  // Index 0 is the serial clock pin, index 1 the bus line
  wire [1:0] pin_raw;
  wire [1:0] pin_sync;
  wire [1:0] pin_prev;
  reg [7:0] rd_mux;
  wire rel_evt;
  wire cmd_evt;
  reg chan_en_q;
  reg wakeup_q;
  reg [4:0] mode_low_q;
  reg rel_trig_q;
  reg cmd_trig_q;
  reg rel_det_q;
  reg cmd_det_q;
  reg [7:0] slave_addr_q;
  reg [7:0] shift_q;
  reg [7:0] int_timing_q;
  reg [2:0] int_status_q;
  reg [2:0] int_mask_q;
  reg [3:0] bit_cnt_q;
  reg shifting_q;
  reg out_latch_q;
  reg addr_phase_q;
  wire sck;
  wire sda;
  wire sck_rise;
  wire sda_rise;
  wire sda_fall;
  wire xfer_start;
  wire xfer_done;
  wire match;
  wire addr_check;
  wire xfer_irq;
  wire [2:0] events;

  function wr_hit;
    input [15:0] a;
    input [15:0] r;
    begin
      wr_hit = (a == r);
    end
  endfunction

  // Local reset release
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Pin synchronisers; only the second stage reads the first
  assign pin_raw = {bus_line_i, serial_clk_i};
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sync
      reg s0_q;
      reg s1_q;
      reg prev_q;
      // Both pins idle high, so a reset to 1 gives no false edge
      always @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
          s0_q <= 1'b1;
          s1_q <= 1'b1;
          prev_q <= 1'b1;
        end else begin
          s0_q <= pin_raw[g];
          s1_q <= s0_q;
          prev_q <= s1_q;
        end
      end
      assign pin_sync[g] = s1_q;
      assign pin_prev[g] = prev_q;
    end
  endgenerate

  // Edges seen about two system cycles after the pin moves
  assign sck = pin_sync[0];
  assign sda = pin_sync[1];
  assign sck_rise = sck & ~pin_prev[0];
  assign sda_rise = sda & ~pin_prev[1];
  assign sda_fall = ~sda & pin_prev[1];
  // Writing the shift register starts a transfer
  assign xfer_start = wr_i & wr_hit(addr_i, `ADDR_SHIFT_REG) & chan_en_q;
  // Done on the eighth sampled rise
  assign xfer_done = shifting_q & sck_rise & (bit_cnt_q == `LAST_BIT_IDX);
  assign match = chan_en_q & (slave_addr_q == shift_q); // RQ3 RQ4
  // Address byte is the first byte after release and command
  assign addr_check = xfer_done & addr_phase_q & wakeup_q;
  assign xfer_irq = xfer_done & (~wakeup_q | // RQ1
                    (addr_phase_q & (slave_addr_q == {shift_q[6:0], sda}))); // RQ2
  // Events fire only when the flag is not yet set, once per signal
  assign cmd_evt = sda_fall & sck & chan_en_q & ~cmd_det_q;
  assign rel_evt = sda_rise & sck & chan_en_q & ~rel_det_q;
  assign events = {cmd_evt, rel_evt, xfer_irq};

  // Mode register; the match bit is computed, not stored
  always @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      chan_en_q <= 1'b0;
      wakeup_q <= 1'b0;
      mode_low_q <= 5'h00;
    end else if (wr_i & wr_hit(addr_i, `ADDR_MODE_CTRL0)) begin
      chan_en_q <= wdata_i[`BIT_CHAN_EN]; // RQ5
      wakeup_q <= wdata_i[`BIT_WAKEUP];
      mode_low_q <= wdata_i[4:0];
    end
  end

  // Slave address, compared against every address byte
  always @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q)
      slave_addr_q <= 8'h00;
    else if (wr_i & wr_hit(addr_i, `ADDR_SLAVE_ADDR))
      slave_addr_q <= wdata_i;
  end

  // Source select bit is stored only; software keeps it 0 for wakeup
  always @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q)
      int_timing_q <= 8'h00;
    else if (wr_i & wr_hit(addr_i, `ADDR_INT_TIMING))
      int_timing_q <= wdata_i; // RQ6
  end

  // Mask shares the status layout
  always @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q)
      int_mask_q <= 3'h0;
    else if (wr_i & wr_hit(addr_i, `ADDR_INT_MASK))
      int_mask_q <= wdata_i[2:0];
  end

  // Trigger bits, detection flags and output latch
  always @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rel_trig_q <= 1'b0; // RQ7
      cmd_trig_q <= 1'b0;
      rel_det_q <= 1'b0;
      cmd_det_q <= 1'b0;
      out_latch_q <= 1'b1;
      addr_phase_q <= 1'b0;
    end else if (!chan_en_q) begin
      rel_trig_q <= 1'b0; // RQ9 RQ11
      cmd_trig_q <= 1'b0;
      rel_det_q <= 1'b0; // RQ13
      cmd_det_q <= 1'b0;
      addr_phase_q <= 1'b0;
      out_latch_q <= 1'b1;
    end else begin
      // Triggers act next cycle, then drop once the latch follows
      if (rel_trig_q) begin
        out_latch_q <= 1'b1; // RQ8
        rel_trig_q <= 1'b0; // RQ9
      end else if (cmd_trig_q) begin
        out_latch_q <= 1'b0; // RQ10
        cmd_trig_q <= 1'b0; // RQ11
      end else if (wr_i & wr_hit(addr_i, `ADDR_BUS_CTRL)) begin
        rel_trig_q <= wdata_i[`BIT_REL_TRIG];
        cmd_trig_q <= wdata_i[`BIT_CMD_TRIG];
      end
      // Release: data rises while clock high; detection wins over clears
      if (sda_rise & sck)
        rel_det_q <= 1'b1; // RQ12
      else if (xfer_start | (addr_check & (slave_addr_q != {shift_q[6:0], sda})))
        rel_det_q <= 1'b0; // RQ13
      if (sda_fall & sck)
        cmd_det_q <= 1'b1; // RQ14
      else if (xfer_start)
        cmd_det_q <= 1'b0;
      if (sda_fall & sck & rel_det_q)
        addr_phase_q <= 1'b1;
      else if (xfer_done)
        addr_phase_q <= 1'b0;
    end
  end

  // Shifter, MSB first: in and out both move on the rising edge
  always @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      shifting_q <= 1'b0;
    end else if (!chan_en_q) begin
      shifting_q <= 1'b0; // RQ5
      bit_cnt_q <= 4'h0;
    end else if (xfer_start) begin
      shift_q <= wdata_i;
      bit_cnt_q <= 4'h0;
      shifting_q <= 1'b1;
    end else if (shifting_q & sck_rise) begin
      shift_q <= {shift_q[6:0], sda};
      bit_cnt_q <= bit_cnt_q + 4'h1;
      if (bit_cnt_q == `LAST_BIT_IDX)
        shifting_q <= 1'b0;
    end
  end

  // Sticky interrupt status, write one to clear; a new event wins
  always @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      int_status_q <= 3'h0;
    end else if (wr_i & wr_hit(addr_i, `ADDR_INT_STATUS)) begin
      int_status_q <= (int_status_q & ~wdata_i[2:0]) | events;
    end else begin
      int_status_q <= int_status_q | events;
    end
  end

  // Read decode; unmapped addresses read 0
  always @* begin
    rd_mux = 8'h00;
    case (addr_i)
      `ADDR_MODE_CTRL0: rd_mux = {chan_en_q, match, wakeup_q, mode_low_q}; // RQ3
      // Triggers read as 0, detection flags never written
      `ADDR_BUS_CTRL: rd_mux = {4'h0, cmd_det_q, rel_det_q, 2'h0}; // RQ15 RQ16
      `ADDR_SLAVE_ADDR: rd_mux = slave_addr_q;
      `ADDR_SHIFT_REG: rd_mux = shift_q;
      `ADDR_INT_STATUS: rd_mux = {5'h00, int_status_q};
      `ADDR_INT_MASK: rd_mux = {5'h00, int_mask_q};
      `ADDR_INT_TIMING: rd_mux = int_timing_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // Level interrupt, one cycle behind status and mask
  always @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(int_status_q & int_mask_q);
    end
  end

  // Open drain: drive low only; the pull-up gives the high level
  always @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bus_line_oe_o <= 1'b0;
      bus_line_o <= 1'b0;
    end else begin
      bus_line_o <= 1'b0;
      if (shifting_q)
        bus_line_oe_o <= chan_en_q & ~shift_q[7];
      else
        bus_line_oe_o <= chan_en_q & ~out_latch_q; // RQ17
    end
  end

  // Read data stand only in the cycle after each cycle with rd_i high, so stale values never linger
  always @(posedge clk_sys_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
    end
  end
endmodule // sbus_ctrl

// ===== bench/sbus_ctrl_checker.sv
// Port-level assertions for the serial bus control block.
// Sees only the block's ports; attached by the bind at the foot.
`include "sbus_ctrl_defs.vh"
module sbus_ctrl_checker (
  input wire clk_sys_i,
  input wire arst_n_i,
  input wire [15:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire serial_clk_i,
  input wire bus_line_i,
  input wire bus_line_oe_o,
  input wire bus_line_o,
  input wire irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic en_q;
  logic [7:0] mask_q;
  wire rd_ctl = rd_i && addr_i == `ADDR_BUS_CTRL;
  wire rd_mode = rd_i && addr_i == `ADDR_MODE_CTRL0;
  wire wr_ctl = wr_i && addr_i == `ADDR_BUS_CTRL && en_q;
  // Shadows of software writes tie outputs to their cause
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_q <= 1'b0;
      mask_q <= 8'h00;
    end else if (wr_i && addr_i == `ADDR_MODE_CTRL0) begin
      en_q <= wdata_i[7];
    end else if (wr_i && addr_i == `ADDR_INT_MASK) begin
      mask_q <= wdata_i;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  a_line_open_drain: assert property (bus_line_o == 1'b0)
    else $error("line output driven high");
  a_cmd_pulls_line: assert property (wr_ctl && wdata_i[1:0] == 2'b10 |-> ##[1:4] bus_line_oe_o)
    else $error("command trigger left line free");
  a_rel_frees_line: assert property (wr_ctl && wdata_i[1:0] == 2'b01 |-> ##[1:4] !bus_line_oe_o)
    else $error("release trigger left line low");
  a_trig_read_zero: assert property (rd_ctl |=> rdata_o[1:0] == 2'b00)
    else $error("trigger bits read nonzero");
  a_flags_off_clear: assert property (rd_ctl && !en_q && !$past(en_q) |=> !rdata_o[2])
    else $error("release flag set while disabled");
  a_match_off_zero: assert property (rd_mode && !en_q && !$past(en_q) |=> !rdata_o[6])
    else $error("match flag set while disabled");
  a_enable_readback: assert property (rd_mode |=> rdata_o[7] == $past(en_q))
    else $error("enable bit readback wrong");
  a_irq_masked: assert property (mask_q == 8'h00 && $past(mask_q) == 8'h00 |-> !irq_o)
    else $error("interrupt while all masked");
  c_rel_trig: cover property (wr_ctl && wdata_i[0]);
  c_irq_rise: cover property ($rose(irq_o));
  c_read_ctl: cover property (rd_ctl);
endmodule // sbus_ctrl_checker
bind sbus_ctrl sbus_ctrl_checker i_chk (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .serial_clk_i(serial_clk_i), .bus_line_i(bus_line_i), .bus_line_oe_o(bus_line_oe_o),
  .bus_line_o(bus_line_o), .irq_o(irq_o));

// ===== bench/sbus_far.sv
// Far-side master on the open-drain line, making the serial clock.
// Assumes a pull-up on the line, resolved by the bench.
module sbus_far (
  input wire line_i,
  output logic sclk_o,
  output logic pull_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clock idles high and stands still outside frames
  initial begin
    sclk_o = 1'b1;
    pull_o = 1'b0;
  end
  task automatic rel_cmd();
    pull_o = 1'b1;
    #400 pull_o = 1'b0;
    #400 pull_o = 1'b1;
    #400;
  endtask
  // Line is left as the last bit had it, so no stray edge while clock is high
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sclk_o = 1'b0;
      #200 pull_o = !b[i];
      #200 sclk_o = 1'b1;
      #400;
    end
  endtask
endmodule // sbus_far

// ===== bench/tb_sbus_ctrl.sv
// Self-checking bench for the serial bus control block.
// Register port on clk_sys_i; the far-side master works the shared line.
`include "sbus_ctrl_defs.vh"
module tb_sbus_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] MODE = `ADDR_MODE_CTRL0;
  localparam logic [15:0] CTL = `ADDR_BUS_CTRL;
  localparam logic [15:0] STS = `ADDR_INT_STATUS;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o, rv;
  logic bus_line_oe_o, bus_line_o, irq_o, sclk, pull;
  int bad_count = 0;
  int n_tests = 0;
  wire line = !(bus_line_oe_o || pull);
  always #50 clk_sys_i = ~clk_sys_i;
  sbus_ctrl i_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_clk_i(sclk),
    .bus_line_i(line), .bus_line_oe_o(bus_line_oe_o), .bus_line_o(bus_line_o), .irq_o(irq_o));
  sbus_far i_far (.line_i(line), .sclk_o(sclk), .pull_o(pull));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  task automatic wait_irq(input logic e);
    for (int i = 0; i < 60 && irq_o !== e; i++) @(posedge clk_sys_i);
    chk("irq_o", irq_o, e);
    if (irq_o !== e)
      complete_run();
  endtask
  initial begin
    #2000000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd(CTL);
    chk("ctrl reset", rv, `RESET_BYTE);
    wr(`ADDR_INT_TIMING, 8'h00);
    wr(MODE, 8'h80);
    rd(MODE);
    chk("enable", rv & 8'hbf, 8'h80);
    wr(CTL, 8'h0c);
    rd(CTL);
    chk("flags ro", rv, 8'h00);
    wr(CTL, 8'h02);
    repeat (6) @(posedge clk_sys_i);
    chk("line cmd", bus_line_oe_o, 1'b1);
    wr(CTL, 8'h01);
    repeat (6) @(posedge clk_sys_i);
    chk("line rel", bus_line_oe_o, 1'b0);
    rd(CTL);
    chk("ctrl seen", rv, 8'h0c);
    $display("test triggers done");
    wr(`ADDR_SHIFT_REG, 8'hff);
    i_far.send_byte(8'h33);
    repeat (10) @(posedge clk_sys_i);
    rd(STS);
    chk("xfer status", rv & 8'h01, 8'h01);
    chk("irq masked", irq_o, 1'b0);
    wr(`ADDR_INT_MASK, 8'h01);
    wait_irq(1'b1);
    wr(STS, 8'h01);
    wait_irq(1'b0);
    $display("test transfer irq done");
    wr(`ADDR_SLAVE_ADDR, 8'h5a);
    wr(MODE, 8'ha0);
    wr(`ADDR_SHIFT_REG, 8'hff);
    i_far.rel_cmd();
    i_far.send_byte(8'h5a);
    wait_irq(1'b1);
    rd(MODE);
    chk("match", rv, 8'he0);
    wr(STS, 8'h01);
    wait_irq(1'b0);
    wr(`ADDR_SHIFT_REG, 8'hff);
    i_far.rel_cmd();
    i_far.send_byte(8'h33);
    repeat (20) @(posedge clk_sys_i);
    chk("no wake", irq_o, 1'b0);
    rd(CTL);
    chk("rel cleared", rv & 8'h04, 8'h00);
    rd(MODE);
    chk("no match", rv, 8'ha0);
    $display("test wakeup done");
    wr(STS, 8'h07);
    wr(MODE, 8'h00);
    wr(`ADDR_SHIFT_REG, 8'hff);
    i_far.send_byte(8'h5a);
    repeat (20) @(posedge clk_sys_i);
    rd(STS);
    chk("stopped", rv, 8'h00);
    rd(MODE);
    chk("mode off", rv, 8'h00);
    rd(CTL);
    chk("ctrl off", rv & 8'h07, 8'h00);
    rd(16'hff70);
    chk("unmapped", rv, 8'h00);
    $display("test disable done");
    complete_run();
  end
endmodule // tb_sbus_ctrl
